// File: src/cfw_config_decode.sv
// Configuration word decoder top with AHB-Lite access for the programmer
`timescale 1ns/1ps
`default_nettype none
module cfw_config_decode #(
    parameter longint PWRUP_CYCLES = cfw_pkg::CFW_PWRUP_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic oscillator_input_pin,
    input wire logic brownout_detect,
    input wire logic supply_good,
    input wire logic ext_reset_n,
    input wire logic wdog_timeout,
    input wire logic irq_pending,
    output logic chip_reset,
    output logic sleeping,
    output logic brownout_reset_enable,
    output logic watchdog_enable_cfg,
    output logic powerup_delay_timer,
    output logic osc_startup_timer,
    output logic crystal_osc_enable,
    output logic [1:0] oscillator_mode_select,
    output logic [12:0] protect_limit,
    output logic protect_on,
    output logic wdog_own_osc_sel
);
    // Synchronisers for pins and foreign clock
    logic [1:0] osc_sy, bo_sy, sg_sy, er_sy, wd_sy, iq_sy;
    logic osc_prev;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_sy <= 2'b00;
            bo_sy <= 2'b00;
            sg_sy <= 2'b00;
            er_sy <= 2'b11;
            wd_sy <= 2'b00;
            iq_sy <= 2'b00;
            osc_prev <= 1'b0;
        end else begin
            osc_sy <= {osc_sy[0], oscillator_input_pin};
            bo_sy <= {bo_sy[0], brownout_detect};
            sg_sy <= {sg_sy[0], supply_good};
            er_sy <= {er_sy[0], ext_reset_n};
            wd_sy <= {wd_sy[0], wdog_timeout};
            iq_sy <= {iq_sy[0], irq_pending};
            osc_prev <= osc_sy[1];
        end
    end
    // crystal or external clock both arrive as edges on the input pin
    wire osc_edge = osc_sy[1] & ~osc_prev;

    // Stored word, erased state all ones
    logic [13:0] cfg_word;
    logic [2:0] ctrl_reg;
    cfw_pkg::cfw_ctrl_s held;

    // AHB-Lite address phase capture
    logic dp_wr, dp_rd;
    logic [31:0] dp_addr;
    wire take = hsel & hready & htrans[1];
    wire prog_mode = ctrl_reg[cfw_pkg::CFW_CTRL_PROGMODE];
    wire in_sleep = ctrl_reg[cfw_pkg::CFW_CTRL_SLEEP];
    wire is8k = ctrl_reg[cfw_pkg::CFW_CTRL_VARIANT8K];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr <= 1'b0;
            dp_rd <= 1'b0;
            dp_addr <= 32'h0000_0000;
        end else begin
            dp_wr <= take & hwrite;
            dp_rd <= take & ~hwrite;
            dp_addr <= haddr;
        end
    end

    wire wr_ctrl = dp_wr && dp_addr == cfw_pkg::CFW_CTRL_OFS;
    // word only reachable in programming mode
    wire wr_prog = dp_wr && dp_addr == cfw_pkg::CFW_PROG_OFS && prog_mode;

    logic chip_reset_i, ost_i, pwr_i;
    wire wake_evt = in_sleep & (~er_sy[1] | wd_sy[1] | iq_sy[1]);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_word <= cfw_pkg::CFW_WORD_RESET;
            ctrl_reg <= 3'b100;
        end else begin
            if (wr_prog) begin
                // programming only clears bits, never sets them
                cfg_word <= cfg_word & hwdata[13:0];
            end
            if (wr_ctrl) begin
                ctrl_reg <= hwdata[2:0];
            end else if (wake_evt) begin
                // wake on reset pin, watchdog or interrupt
                ctrl_reg[cfw_pkg::CFW_CTRL_SLEEP] <= 1'b0;
            end
        end
    end

    // capture the word only while the chip is held in reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            held <= cfw_pkg::cfw_ctrl_s'(7'h7F);
        end else if (chip_reset_i) begin
            held.brownout_reset_enable <= cfg_word[cfw_pkg::CFW_BIT_BROWNOUT];
            held.code_protect_select <= cfg_word[cfw_pkg::CFW_BIT_CP_HI:cfw_pkg::CFW_BIT_CP_LO];
            // active-low power-up enable at bit 3
            held.powerup_delay_enable_n <= cfg_word[cfw_pkg::CFW_BIT_PWRUP_N];
            held.watchdog_enable_cfg <= cfg_word[cfw_pkg::CFW_BIT_WDOG];
            held.oscillator_mode_select <= cfw_pkg::cfw_osc_e'(cfg_word[cfw_pkg::CFW_BIT_OSC_HI:cfw_pkg::CFW_BIT_OSC_LO]);
        end
    end

    function automatic logic [12:0] limit_of(input logic [1:0] cp, input logic big);
        logic [12:0] r;
        r = 13'h0000;
        unique case (cp)
            2'b10: r = big ? cfw_pkg::CFW_HALF_8K : cfw_pkg::CFW_HALF_4K;
            2'b01: r = big ? cfw_pkg::CFW_MOST_8K : cfw_pkg::CFW_MOST_4K;
            2'b00: r = big ? cfw_pkg::CFW_ALL_8K : cfw_pkg::CFW_ALL_4K;
            2'b11: r = 13'h0000;
        endcase
        return r;
    endfunction
    // 4K part aliases the upper half onto the lower
    wire [12:0] alias_mask = is8k ? 13'h1FFF : (cfw_pkg::CFW_ALIAS_4K - 13'h0001);
    wire [12:0] next_limit = limit_of(held.code_protect_select, is8k) & alias_mask;
    wire next_prot_on = held.code_protect_select != 2'b11;

    cfw_reset_seq #(.PWRUP_CYCLES(PWRUP_CYCLES)) u_seq (
        .hclk(hclk),
        .hresetn(hresetn),
        .brownout_now(bo_sy[1]),
        .supply_good(sg_sy[1]),
        .wake(wake_evt),
        .osc_edge(osc_edge),
        .ctrl(held),
        .chip_reset(chip_reset_i),
        .ost_active(ost_i),
        .pwrup_active(pwr_i)
    );

    wire [31:0] stat_word = {21'h0, is8k, ost_i, pwr_i, chip_reset_i, held};
    wire [31:0] next_rdata =
        (haddr == cfw_pkg::CFW_CTRL_OFS) ? {29'h0, ctrl_reg} :
        (haddr == cfw_pkg::CFW_STAT_OFS) ? stat_word :
        (haddr == cfw_pkg::CFW_PROG_OFS) ? (prog_mode ? {18'h0, cfg_word} : 32'h0000_0000) :
        (haddr == cfw_pkg::CFW_PROT_OFS) ? {18'h0, next_prot_on, next_limit} :
        (haddr == cfw_pkg::CFW_CFGADDR_OFS) ? cfw_pkg::CFW_CFG_ADDR : 32'h0000_0000;

    // Registered outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chip_reset <= 1'b1;
            sleeping <= 1'b0;
            brownout_reset_enable <= 1'b1;
            watchdog_enable_cfg <= 1'b1;
            powerup_delay_timer <= 1'b0;
            osc_startup_timer <= 1'b0;
            crystal_osc_enable <= 1'b0;
            oscillator_mode_select <= 2'b11;
            protect_limit <= 13'h0000;
            protect_on <= 1'b0;
            wdog_own_osc_sel <= 1'b1;
        end else begin
            chip_reset <= chip_reset_i;
            sleeping <= in_sleep;
            brownout_reset_enable <= held.brownout_reset_enable;
            // only the held word gates the watchdog
            watchdog_enable_cfg <= held.watchdog_enable_cfg;
            powerup_delay_timer <= pwr_i;
            osc_startup_timer <= ost_i;
            crystal_osc_enable <= held.oscillator_mode_select != cfw_pkg::CFW_OSC_RC;
            oscillator_mode_select <= held.oscillator_mode_select;
            protect_limit <= next_limit;
            protect_on <= next_prot_on;
            // watchdog always on its own RC clock
            wdog_own_osc_sel <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else begin
            hrdata <= (take & ~hwrite) ? next_rdata : 32'h0000_0000;
        end
    end

    // Zero-wait slave, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Sequence helper
    sequence s_ost_done;
        osc_edge && ost_i && u_seq.cnt == 22'd1023;
    endsequence

    a_word_polarity: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_prog |=> (cfg_word & ~$past(cfg_word)) == 14'h0000)
        else $error("programmed bit returned to one");
    a_prog_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        (dp_wr && !prog_mode) |=> $stable(cfg_word))
        else $error("word changed outside programming");
    a_brown_follow: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 brownout_reset_enable == $past(held.brownout_reset_enable))
        else $error("brown-out enable mismatch");
    a_prot_full8k: assert property (@(posedge hclk) disable iff (!hresetn)
        (is8k && held.code_protect_select == 2'b00) |=> protect_limit == 13'h1FFF)
        else $error("8K full protect limit wrong");
    a_prot_alias4k: assert property (@(posedge hclk) disable iff (!hresetn)
        !is8k |-> next_limit[12] == 1'b0)
        else $error("4K limit not aliased");
    a_pwrup_low: assert property (@(posedge hclk) disable iff (!hresetn)
        (pwr_i && !$past(pwr_i)) |-> !held.powerup_delay_enable_n)
        else $error("power delay ran while disabled");
    a_wdog_cfg: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 watchdog_enable_cfg == $past(held.watchdog_enable_cfg))
        else $error("watchdog enable mismatch");
    a_osc_mode: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 crystal_osc_enable == ($past(held.oscillator_mode_select) != cfw_pkg::CFW_OSC_RC))
        else $error("crystal enable mismatch");
    a_held_stable: assert property (@(posedge hclk) disable iff (!hresetn)
        (!chip_reset_i && !$past(chip_reset_i)) |-> $stable(held))
        else $error("controls changed while running");
    a_ost_release: assert property (@(posedge hclk) disable iff (!hresetn)
        s_ost_done ##0 !(held.brownout_reset_enable && bo_sy[1]) |=> !chip_reset_i)
        else $error("start-up count did not release");
    a_ost_rc: assert property (@(posedge hclk) disable iff (!hresetn)
        ost_i |-> held.oscillator_mode_select != cfw_pkg::CFW_OSC_RC)
        else $error("start-up count in RC mode");
    a_sleep_wake: assert property (@(posedge hclk) disable iff (!hresetn)
        (wake_evt && !wr_ctrl) |=> !in_sleep)
        else $error("wake event ignored");

    // Bus answer checks
    a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp)
        else $error("bus answer not ready and okay");
    a_read_idle: assert property (@(posedge hclk) disable iff (!hresetn)
        !(take && !hwrite) |=> hrdata == 32'h0000_0000)
        else $error("read data outside data phase");
    a_read_word: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && haddr == cfw_pkg::CFW_CFGADDR_OFS) |=> hrdata == cfw_pkg::CFW_CFG_ADDR)
        else $error("word location read wrong");
    a_read_locked: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && haddr == cfw_pkg::CFW_PROG_OFS && !prog_mode) |=> hrdata == 32'h0000_0000)
        else $error("word readable outside programming");

    // Protection decode checks
    a_prot_off: assert property (@(posedge hclk) disable iff (!hresetn)
        held.code_protect_select == 2'b11 |=> !protect_on)
        else $error("protection on with field erased");
    a_prot_on: assert property (@(posedge hclk) disable iff (!hresetn)
        held.code_protect_select != 2'b11 |=> protect_on)
        else $error("protection off with field programmed");
    a_prot_half8k: assert property (@(posedge hclk) disable iff (!hresetn)
        (is8k && held.code_protect_select == 2'b10) |=> protect_limit == cfw_pkg::CFW_HALF_8K)
        else $error("8K half protect limit wrong");
    a_prot_most8k: assert property (@(posedge hclk) disable iff (!hresetn)
        (is8k && held.code_protect_select == 2'b01) |=> protect_limit == cfw_pkg::CFW_MOST_8K)
        else $error("8K most protect limit wrong");
    a_prot_half4k: assert property (@(posedge hclk) disable iff (!hresetn)
        (!is8k && held.code_protect_select == 2'b10) |=> protect_limit == cfw_pkg::CFW_HALF_4K)
        else $error("4K half protect limit wrong");
    a_prot_most4k: assert property (@(posedge hclk) disable iff (!hresetn)
        (!is8k && held.code_protect_select == 2'b01) |=> protect_limit == cfw_pkg::CFW_MOST_4K)
        else $error("4K most protect limit wrong");
    a_prot_full4k: assert property (@(posedge hclk) disable iff (!hresetn)
        (!is8k && held.code_protect_select == 2'b00) |=> protect_limit == cfw_pkg::CFW_ALL_4K)
        else $error("4K full protect limit wrong");

    // Reset sequence checks
    sequence s_brown_wait;
        chip_reset_i && !pwr_i && !ost_i && !sg_sy[1];
    endsequence
    a_mode_follow: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 oscillator_mode_select == $past(held.oscillator_mode_select))
        else $error("oscillator mode mismatch");
    a_own_osc: assert property (@(posedge hclk) disable iff (!hresetn)
        wdog_own_osc_sel)
        else $error("watchdog not on own oscillator");
    a_chip_follow: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 chip_reset == $past(chip_reset_i))
        else $error("chip reset output mismatch");
    a_brown_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (held.brownout_reset_enable && bo_sy[1]) |=> chip_reset_i)
        else $error("enabled brown-out did not reset");
    a_supply_wait: assert property (@(posedge hclk) disable iff (!hresetn)
        s_brown_wait |=> chip_reset_i && !pwr_i && !ost_i)
        else $error("left brown-out before supply good");
    a_pwr_holds: assert property (@(posedge hclk) disable iff (!hresetn)
        pwr_i |-> chip_reset_i)
        else $error("power delay without reset held");
    a_ost_holds: assert property (@(posedge hclk) disable iff (!hresetn)
        ost_i |-> chip_reset_i)
        else $error("start-up count without reset held");
    a_sleep_out: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 sleeping == $past(in_sleep))
        else $error("sleep output mismatch");
    a_capture_brown: assert property (@(posedge hclk) disable iff (!hresetn)
        chip_reset_i |=> held.brownout_reset_enable == $past(cfg_word[cfw_pkg::CFW_BIT_BROWNOUT]))
        else $error("brown-out bit not captured");
    a_capture_pwr: assert property (@(posedge hclk) disable iff (!hresetn)
        chip_reset_i |=> held.powerup_delay_enable_n == $past(cfg_word[cfw_pkg::CFW_BIT_PWRUP_N]))
        else $error("power delay bit not captured");
endmodule
`default_nettype wire

// File: src/cfw_pkg.sv
// Package for the configuration word decoder: map, fields, timing constants
package cfw_pkg;
    localparam logic [31:0] CFW_CFG_ADDR = 32'h0000_2007;
    localparam logic [31:0] CFW_CTRL_OFS = 32'h0000_0000;
    localparam logic [31:0] CFW_STAT_OFS = 32'h0000_0004;
    localparam logic [31:0] CFW_PROG_OFS = 32'h0000_0008;
    localparam logic [31:0] CFW_PROT_OFS = 32'h0000_000C;
    localparam logic [31:0] CFW_CFGADDR_OFS = 32'h0000_0010;
    localparam int CFW_WORD_W = 14;
    localparam logic [13:0] CFW_WORD_RESET = 14'h3FFF;
    localparam int CFW_BIT_BROWNOUT = 6;
    localparam int CFW_BIT_CP_HI = 5;
    localparam int CFW_BIT_CP_LO = 4;
    localparam int CFW_BIT_PWRUP_N = 3;
    localparam int CFW_BIT_WDOG = 2;
    localparam int CFW_BIT_OSC_HI = 1;
    localparam int CFW_BIT_OSC_LO = 0;
    localparam int CFW_CTRL_PROGMODE = 0;
    localparam int CFW_CTRL_SLEEP = 1;
    localparam int CFW_CTRL_VARIANT8K = 2;
    localparam logic [12:0] CFW_HALF_8K = 13'h0FFF;
    localparam logic [12:0] CFW_MOST_8K = 13'h1EFF;
    localparam logic [12:0] CFW_ALL_8K = 13'h1FFF;
    localparam logic [12:0] CFW_HALF_4K = 13'h07FF;
    localparam logic [12:0] CFW_MOST_4K = 13'h0EFF;
    localparam logic [12:0] CFW_ALL_4K = 13'h0FFF;
    localparam logic [12:0] CFW_ALIAS_4K = 13'h1000;
    localparam int CFW_CLK_HZ = 40_000_000;
    localparam int CFW_PWRUP_MS = 72;
    localparam longint CFW_PWRUP_CYC = (longint'(CFW_PWRUP_MS) * CFW_CLK_HZ) / 1000;
    localparam int CFW_OST_CYCLES = 1024;
    localparam int CFW_CNT_W = 22;

    typedef enum logic [1:0] {
        CFW_OSC_LP = 2'b00,
        CFW_OSC_XT = 2'b01,
        CFW_OSC_HS = 2'b10,
        CFW_OSC_RC = 2'b11
    } cfw_osc_e;

    typedef struct packed {
        logic brownout_reset_enable;
        logic [1:0] code_protect_select;
        logic powerup_delay_enable_n;
        logic watchdog_enable_cfg;
        cfw_osc_e oscillator_mode_select;
    } cfw_ctrl_s;

    typedef struct packed {
        logic por;
        logic brownout;
        logic ext_reset;
        logic wdog_wake;
        logic irq_wake;
    } cfw_event_s;
endpackage

// File: src/cfw_reset_seq.sv
// Reset delay sequencer: power-up delay, oscillator start-up count, brown-out hold
`timescale 1ns/1ps
`default_nettype none
module cfw_reset_seq #(
    parameter longint PWRUP_CYCLES = cfw_pkg::CFW_PWRUP_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic brownout_now,
    input wire logic supply_good,
    input wire logic wake,
    input wire logic osc_edge,
    input wire cfw_pkg::cfw_ctrl_s ctrl,
    output logic chip_reset,
    output logic ost_active,
    output logic pwrup_active
);
    typedef enum logic [2:0] {SQ_BROWN, SQ_PWRUP, SQ_OST, SQ_RUN} cfw_seq_e;
    cfw_seq_e state, next_state;
    logic [cfw_pkg::CFW_CNT_W-1:0] cnt, next_cnt;
    logic from_por;
    wire crystal = ctrl.oscillator_mode_select != cfw_pkg::CFW_OSC_RC;
    wire pwr_on = ~ctrl.powerup_delay_enable_n;
    wire brown_hit = ctrl.brownout_reset_enable & brownout_now;
    wire [cfw_pkg::CFW_CNT_W-1:0] pwr_last = cfw_pkg::CFW_CNT_W'(PWRUP_CYCLES - 1);
    wire [cfw_pkg::CFW_CNT_W-1:0] ost_last = cfw_pkg::CFW_CNT_W'(cfw_pkg::CFW_OST_CYCLES - 1);
    // Start-up count after the delay only on power-on, crystal modes only
    wire cfw_seq_e after_pwr = (crystal && from_por) ? SQ_OST : SQ_RUN;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        unique case (state)
            SQ_BROWN: begin
                next_cnt = '0;
                if (supply_good) begin
                    next_state = pwr_on ? SQ_PWRUP : after_pwr;
                end
            end
            SQ_PWRUP: begin
                next_cnt = cnt + 1'b1;
                if (cnt == pwr_last) begin
                    next_state = after_pwr;
                    next_cnt = '0;
                end
            end
            SQ_OST: begin
                if (osc_edge) begin
                    next_cnt = cnt + 1'b1;
                end
                if (osc_edge && cnt == ost_last) begin
                    next_state = SQ_RUN;
                    next_cnt = '0;
                end
            end
            SQ_RUN: begin
                next_cnt = '0;
                // start-up count also on sleep wake in crystal modes
                if (wake && crystal) begin
                    next_state = SQ_OST;
                end
            end
        endcase
        if (brown_hit) begin
            next_state = SQ_BROWN;
            next_cnt = '0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= SQ_BROWN;
            cnt <= '0;
            from_por <= 1'b1;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            from_por <= from_por & (state != SQ_RUN);
        end
    end

    assign chip_reset = state != SQ_RUN;
    assign ost_active = state == SQ_OST;
    assign pwrup_active = state == SQ_PWRUP;
endmodule
`default_nettype wire

// File: dv/cfw_prog_model.sv
// Device programmer model: AHB-Lite master for single word transfers
`timescale 1ns/1ps
`default_nettype none
module cfw_prog_model (
    input wire logic hclk,
    input wire logic hready,
    output var logic hsel = 1'b0,
    output var logic [31:0] haddr = 32'h0,
    output var logic [1:0] htrans = 2'h0,
    output var logic hwrite = 1'b0,
    output var logic [2:0] hsize = 3'h2,
    output var logic [31:0] hwdata = 32'h0
);
    logic [31:0] exp_q[$];
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        haddr <= ~a;
        hwdata <= wr ? d : ~hwdata;
        if (!wr) exp_q.push_back(d);
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        // Released data bus must not keep the last value
        hwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// File: dv/cfw_config_decode_tb.sv
// Testbench for the configuration word decoder
`timescale 1ns/1ps
`default_nettype none
module cfw_config_decode_tb;
    localparam longint PWR = 20;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic osc = 1'b0, bo_det = 1'b0, sup_good = 1'b1, ext_rst_n = 1'b1, wdog_to = 1'b0, irq = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, rd_dp = 1'b0;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, osc_mode;
    logic [2:0] hsize;
    logic chip_reset, sleeping, bo_en, wd_en, pwr_t, ost_t, xtal_en, pon, own_osc;
    logic [12:0] plimit;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;

    always #12.5 hclk = ~hclk;
    always @(posedge hclk) osc <= ~osc;

    cfw_prog_model i_cfw_prog_model (.hclk(hclk), .hready(hreadyout), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    cfw_config_decode #(.PWRUP_CYCLES(PWR)) i_cfw_config_decode (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .oscillator_input_pin(osc), .brownout_detect(bo_det), .supply_good(sup_good),
        .ext_reset_n(ext_rst_n), .wdog_timeout(wdog_to), .irq_pending(irq), .chip_reset(chip_reset),
        .sleeping(sleeping), .brownout_reset_enable(bo_en), .watchdog_enable_cfg(wd_en),
        .powerup_delay_timer(pwr_t), .osc_startup_timer(ost_t), .crystal_osc_enable(xtal_en),
        .oscillator_mode_select(osc_mode), .protect_limit(plimit), .protect_on(pon),
        .wdog_own_osc_sel(own_osc));

    task automatic end_of_test();
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check_port(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_rd(input logic [31:0] got, input logic [31:0] exp);
        check_port(got, exp);
    endtask

    // Read data checked against the oldest note
    always @(posedge hclk) begin
        if (rd_dp && hreadyout === 1'b1) begin
            check_rd(hrdata, i_cfw_prog_model.exp_q.pop_front());
            check_port(32'(hresp), 32'h0);
        end
        rd_dp <= hsel & htrans[1] & ~hwrite & hreadyout;
        cycles++;
        if (cycles == 90000) begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        i_cfw_prog_model.xfer(1'b1, a, d);
        @(posedge hclk);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        i_cfw_prog_model.xfer(1'b0, a, e);
    endtask

    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask

    task automatic brown(input logic exp_rst);
        bo_det <= 1'b1;
        sup_good <= 1'b0;
        repeat (6) @(posedge hclk);
        check_port(32'(chip_reset), 32'(exp_rst));
        bo_det <= 1'b0;
        sup_good <= 1'b1;
        @(posedge hclk);
    endtask

    // Bounded wait for release, counting power delay cycles
    task automatic settle(output int np);
        int n;
        np = 0;
        n = 0;
        while ((chip_reset | ost_t) !== 1'b0 && n < 5000) begin
            @(posedge hclk);
            n++;
            np += int'(pwr_t === 1'b1);
        end
    endtask

    initial begin
        int np;
        logic [31:0] w;
        logic v8;
        logic [12:0] lim;
        void'($urandom(32'hBF4423B0));
        do_reset();
        // erased word decodes as all ones, protection off
        check_port(32'({bo_en, wd_en, osc_mode, pon, own_osc}), 32'h3D);
        rd(cfw_pkg::CFW_CFGADDR_OFS, cfw_pkg::CFW_CFG_ADDR);
        wr(cfw_pkg::CFW_CTRL_OFS, 32'h4);
        wr(cfw_pkg::CFW_PROG_OFS, 32'h0);
        rd(cfw_pkg::CFW_PROG_OFS, 32'h0);
        wr(cfw_pkg::CFW_CTRL_OFS, 32'h5);
        rd(cfw_pkg::CFW_PROG_OFS, 32'h3FFF);
        rd(32'h40, 32'h0);
        for (int i = 0; i < 16; i++) begin
            w = $urandom();
            w[5:4] = i[3:2];
            w[1:0] = i[1:0];
            w[6] = i[0];
            w[3] = i[1] ^ i[2];
            v8 = w[20];
            do_reset();
            wr(cfw_pkg::CFW_CTRL_OFS, {29'h0, v8, 2'b01});
            wr(cfw_pkg::CFW_PROG_OFS, w);
            rd(cfw_pkg::CFW_PROG_OFS, {18'h0, w[13:0]});
            brown(1'b1);
            settle(np);
            check_port(32'({bo_en, wd_en, osc_mode}), 32'({w[6], w[2], w[1:0]}));
            check_port(32'(xtal_en), 32'(w[1:0] != 2'b11));
            check_port(32'(own_osc), 32'h1);
            // power delay only when bit clear
            check_port(32'(np >= (w[3] ? 0 : PWR - 2) && np <= (w[3] ? 0 : PWR + 2)), 32'h1);
            case (w[5:4])
                2'b10: lim = v8 ? cfw_pkg::CFW_HALF_8K : cfw_pkg::CFW_HALF_4K;
                2'b01: lim = v8 ? cfw_pkg::CFW_MOST_8K : cfw_pkg::CFW_MOST_4K;
                default: lim = v8 ? cfw_pkg::CFW_ALL_8K : cfw_pkg::CFW_ALL_4K;
            endcase
            check_port(32'({pon, pon ? plimit : 13'h0}), 32'({w[5:4] != 2'b11, (w[5:4] == 2'b11) ? 13'h0 : lim}));
            wr(cfw_pkg::CFW_PROG_OFS, 32'h0);
            rd(cfw_pkg::CFW_PROG_OFS, 32'h0);
            check_port(32'({bo_en, wd_en, osc_mode}), 32'({w[6], w[2], w[1:0]}));
            if (!w[6]) brown(1'b0);
            if (i == 2) begin
                for (int s = 0; s < 3; s++) begin
                    wr(cfw_pkg::CFW_CTRL_OFS, {29'h0, v8, 2'b11});
                    @(posedge hclk);
                    check_port(32'(sleeping), 32'h1);
                    irq <= (s == 0);
                    wdog_to <= (s == 1);
                    ext_rst_n <= (s != 2);
                    repeat (2) @(posedge hclk);
                    irq <= 1'b0;
                    wdog_to <= 1'b0;
                    ext_rst_n <= 1'b1;
                    repeat (6) @(posedge hclk);
                    check_port(32'(sleeping), 32'h0);
                    check_port(32'(ost_t), 32'h1);
                    settle(np);
                end
            end
        end
        end_of_test();
    end
endmodule
`default_nettype wire
